/* File: rmw_pkg.sv */
// Package for the rotate-and-mask word unit: register map, control word layout,
// operation codes and condition-field packing.
// Assumes a 32-bit APB3 register bus and one 40 MHz clock in the surrounding core.
package rmw_pkg;

    // ========================================================================
    // Word and field widths
    // ========================================================================
    localparam int unsigned WORD_W  = 32;
    localparam int unsigned ROT_W   = 5;
    localparam int unsigned POS_W   = 6;
    localparam int unsigned CR_W    = 4;
    localparam int unsigned CNT_W   = 16;
    localparam int unsigned ADDR_W  = 8;

    // ========================================================================
    // Register byte offsets on the APB bus
    // ========================================================================
    localparam logic [ADDR_W-1:0] OFS_SOURCE  = 8'h00;  // source_reg operand
    localparam logic [ADDR_W-1:0] OFS_TARGET  = 8'h04;  // target_reg, operand and result
    localparam logic [ADDR_W-1:0] OFS_COUNT   = 8'h08;  // count_reg operand
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h0C;  // writing it executes one operation
    localparam logic [ADDR_W-1:0] OFS_CR0     = 8'h10;  // condition field 0, read only
    localparam logic [ADDR_W-1:0] OFS_XER     = 8'h14;  // exception register, software owned
    localparam logic [ADDR_W-1:0] OFS_OPCOUNT = 8'h18;  // executed operation count, read only

    // ========================================================================
    // Reset values
    // ========================================================================
    localparam logic [WORD_W-1:0] RST_WORD = 32'h0000_0000;
    localparam logic [CR_W-1:0]   RST_CR0  = 4'h0;
    localparam logic [CNT_W-1:0]  RST_CNT  = 16'h0000;
    localparam logic [POS_W-1:0]  POS_ONE  = 6'h01;
    localparam int unsigned       XER_SO_BIT = 31;      // Summary-overflow bit in the XER word

    // ========================================================================
    // Operation codes
    // ========================================================================
    typedef enum logic [1:0] {
        RMW_OP_INSERT_IMM = 2'h0,   // Rotate by rotate_count, insert under mask
        RMW_OP_AND_IMM    = 2'h1,   // Rotate by rotate_count, AND with mask
        RMW_OP_AND_REG    = 2'h2,   // Rotate by count_reg, AND with mask
        RMW_OP_INSERT_REG = 2'h3    // Rotate by count_reg, insert under mask
    } rmw_op_t;

    // Control word, low 18 bits of a CONTROL write
    typedef struct packed {
        rmw_op_t          op;
        logic             record_flag;
        logic [ROT_W-1:0] rotate_count;
        logic [ROT_W-1:0] mask_begin;
        logic [ROT_W-1:0] mask_end;
    } rmw_ctrl_t;

    localparam int unsigned CTRL_W = $bits(rmw_ctrl_t);
    localparam rmw_ctrl_t   RST_CTRL = '0;

    // Condition field 0, packed so that a negative result reads as 4'h8
    typedef struct packed {
        logic less_than_zero_flag;
        logic greater_than_zero_flag;
        logic zero_result_flag;
        logic summary_overflow;
    } rmw_cr_t;

endpackage

/* File: rmw_mask_gen.sv */
// Mask generator of the rotate-and-mask word unit.
// Assumes bit 0 is the most significant bit; purely combinational, no clock.
`timescale 1ns/1ps
module rmw_mask_gen (
    input  wire logic [rmw_pkg::ROT_W-1:0]  mask_begin,  // First bit of the mask, MSB-first numbering
    input  wire logic [rmw_pkg::ROT_W-1:0]  mask_end,    // Last bit of the mask, MSB-first numbering
    output logic      [rmw_pkg::WORD_W-1:0] mask         // Generated mask, mask[31] is bit 0
);

    // ========================================================================
    // Mask from begin and end bounds
    // ========================================================================
    logic [rmw_pkg::POS_W-1:0] begin_w;
    logic [rmw_pkg::POS_W-1:0] end_p1;

    // Widen both bounds so that end plus one cannot wrap
    assign begin_w = {1'b0, mask_begin};
    assign end_p1  = {1'b0, mask_end} + rmw_pkg::POS_ONE;

    // Walk each MSB-first position and decide its mask bit
    always_comb begin
        logic [rmw_pkg::POS_W-1:0] pos;
        pos  = '0;
        mask = '0;
        for (int p = 0; p < int'(rmw_pkg::WORD_W); p++) begin
            pos = rmw_pkg::POS_W'(p);
            if (begin_w < end_p1) begin
                mask[rmw_pkg::WORD_W-1-p] = (pos >= begin_w) && (pos < end_p1);
            end else if (begin_w == end_p1) begin
                mask[rmw_pkg::WORD_W-1-p] = 1'b1;
            end else begin
                mask[rmw_pkg::WORD_W-1-p] = !((pos >= end_p1) && (pos < begin_w));
            end
        end
    end

endmodule

/* File: rmw_unit.sv */
// Rotate-and-mask word unit: APB3 register slave plus a one-step rotate/mask datapath.
// Assumes an APB3 master on CLK (40 MHz), synchronous active-high RESET, no interrupts.
//
// Overview of operation
// - Immediate insert rotates the source word left by the rotate_count field.
// - Insert takes rotated bits where mask is 1, keeps target bits where 0.
// - Begin below end plus one: ones from begin through end, zeros elsewhere.
// - Begin equal to end plus one: mask is all ones.
// - Begin above end plus one: zeros from end+1 to begin-1, ones elsewhere.
// - Immediate AND writes rotated word ANDed with mask as the whole target.
// - Immediate AND takes its rotate amount from the rotate_count field.
// - Register variants rotate by the low five bits (27-31) of count_reg.
// - Register AND writes count-rotated word ANDed with mask into target.
// - Record flag set: update LT, GT, EQ of field 0 versus zero, copy SO from the exception register.
// - Record flag clear: condition field 0 stays unchanged.
// - No operation ever writes the exception register or its overflow bits.
// - Register insert rotates by count_reg and inserts only where mask is 1.
`timescale 1ns/1ps
module rmw_unit (
    input  wire logic                              CLK,      // 40 MHz clock
    input  wire logic                              RESET,    // Synchronous reset, active high
    input  wire logic                              PSEL,     // APB select
    input  wire logic                              PENABLE,  // APB access phase
    input  wire logic                              PWRITE,   // APB direction, high for write
    input  wire logic [rmw_pkg::ADDR_W-1:0]        PADDR,    // APB byte address
    input  wire logic [rmw_pkg::WORD_W-1:0]        PWDATA,   // APB write data
    output logic      [rmw_pkg::WORD_W-1:0]        PRDATA,   // APB read data
    output logic                                   PREADY,   // APB ready, high in the first access cycle, no wait states
    output logic                                   PSLVERR,  // APB error on unmapped address
    output logic      [rmw_pkg::WORD_W-1:0]        RESULT,   // Current target_reg value
    output logic      [rmw_pkg::CR_W-1:0]          CR0_FLAGS // Condition field 0, LT GT EQ SO
);

    // ========================================================================
    // Declarations
    // ========================================================================
    // Software-visible registers
    logic [rmw_pkg::WORD_W-1:0] source_r;
    logic [rmw_pkg::WORD_W-1:0] target_r;
    logic [rmw_pkg::WORD_W-1:0] count_r;
    logic [rmw_pkg::WORD_W-1:0] xer_r;
    rmw_pkg::rmw_ctrl_t         ctrl_r;
    rmw_pkg::rmw_cr_t           cr0_r;
    logic [rmw_pkg::CNT_W-1:0]  opcount_r;
    logic [rmw_pkg::WORD_W-1:0] prdata_r;
    logic                       pready_r;
    logic                       pslverr_r;

    // Bus decode, write strobes and datapath nets
    logic                       setup_ph;
    logic                       access_done;
    logic                       wr_done;
    logic                       addr_ok;
    logic                       exec;
    logic                       wr_source;
    logic                       wr_target;
    logic                       wr_count;
    logic                       wr_xer;
    rmw_pkg::rmw_ctrl_t         ctrl_new;
    logic [rmw_pkg::ROT_W-1:0]  rot_amt;
    logic [rmw_pkg::WORD_W-1:0] rotated;
    logic [rmw_pkg::WORD_W-1:0] mask;
    logic [rmw_pkg::WORD_W-1:0] result_nxt;
    rmw_pkg::rmw_cr_t           cr0_nxt;
    logic [rmw_pkg::WORD_W-1:0] rd_mux;

    // ========================================================================
    // Functions
    // ========================================================================

    // Rotate a word left; with MSB-first numbering bits move toward bit 0
    function automatic logic [rmw_pkg::WORD_W-1:0] rotl(
        input logic [rmw_pkg::WORD_W-1:0] val,
        input logic [rmw_pkg::ROT_W-1:0]  amt
    );
        logic [2*rmw_pkg::WORD_W-1:0] dbl;
        dbl  = {val, val} << amt;
        rotl = dbl[2*rmw_pkg::WORD_W-1:rmw_pkg::WORD_W];
    endfunction

    // Compare a result against zero and fill condition field 0
    function automatic rmw_pkg::rmw_cr_t cmp_zero(
        input logic [rmw_pkg::WORD_W-1:0] val,
        input logic                       so_bit
    );
        rmw_pkg::rmw_cr_t cr;
        cr.less_than_zero_flag    = val[rmw_pkg::WORD_W-1];
        cr.greater_than_zero_flag = !val[rmw_pkg::WORD_W-1] && (val != '0);
        cr.zero_result_flag       = (val == '0);
        cr.summary_overflow       = so_bit;
        cmp_zero = cr;
    endfunction

    // Insert rotated bits where the mask is 1, keep the old target bits elsewhere
    function automatic logic [rmw_pkg::WORD_W-1:0] insert_merge(
        input logic [rmw_pkg::WORD_W-1:0] rot,
        input logic [rmw_pkg::WORD_W-1:0] old,
        input logic [rmw_pkg::WORD_W-1:0] msk
    );
        insert_merge = (rot & msk) | (old & ~msk);
    endfunction

    // True when an address names one of the mapped registers
    function automatic logic is_mapped(input logic [rmw_pkg::ADDR_W-1:0] a);
        is_mapped = (a == rmw_pkg::OFS_SOURCE)  ||
                    (a == rmw_pkg::OFS_TARGET)  ||
                    (a == rmw_pkg::OFS_COUNT)   ||
                    (a == rmw_pkg::OFS_CONTROL) ||
                    (a == rmw_pkg::OFS_CR0)     ||
                    (a == rmw_pkg::OFS_XER)     ||
                    (a == rmw_pkg::OFS_OPCOUNT);
    endfunction

    // ========================================================================
    // APB phase decode
    // ========================================================================

    // Setup cycle, and the access edge at which a transfer completes
    assign setup_ph    = PSEL && !PENABLE;
    assign access_done = PSEL && PENABLE && pready_r;
    assign addr_ok     = is_mapped(PADDR);

    // Completed writes, and the one that launches an operation
    assign wr_done     = access_done && PWRITE && addr_ok;
    assign exec        = wr_done && (PADDR == rmw_pkg::OFS_CONTROL);

    // One write strobe per software-writable register
    assign wr_source = wr_done && (PADDR == rmw_pkg::OFS_SOURCE);
    assign wr_target = wr_done && (PADDR == rmw_pkg::OFS_TARGET);
    assign wr_count  = wr_done && (PADDR == rmw_pkg::OFS_COUNT);
    assign wr_xer    = wr_done && (PADDR == rmw_pkg::OFS_XER);

    // Control word carried by the write that launches an operation
    assign ctrl_new = rmw_pkg::rmw_ctrl_t'(PWDATA[rmw_pkg::CTRL_W-1:0]);

    // Ready rises in the access cycle and drops after it: no wait states
    always_ff @(posedge CLK) begin
        if (RESET) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= setup_ph;
        end
    end

    // Error flag for unmapped addresses, valid with ready
    always_ff @(posedge CLK) begin
        if (RESET) begin
            pslverr_r <= 1'b0;
        end else begin
            pslverr_r <= setup_ph && !addr_ok;
        end
    end

    // ========================================================================
    // Datapath
    // ========================================================================

    // Pick the rotate amount by operation
    always_comb begin
        unique case (ctrl_new.op)
            rmw_pkg::RMW_OP_INSERT_IMM: rot_amt = ctrl_new.rotate_count;
            rmw_pkg::RMW_OP_AND_IMM:    rot_amt = ctrl_new.rotate_count;
            rmw_pkg::RMW_OP_AND_REG:    rot_amt = count_r[rmw_pkg::ROT_W-1:0];
            rmw_pkg::RMW_OP_INSERT_REG: rot_amt = count_r[rmw_pkg::ROT_W-1:0];
        endcase
    end

    // Rotate the source word
    assign rotated = rotl(source_r, rot_amt);

    // Mask from the bounds of the launching control word
    rmw_mask_gen u_mask (
        .mask_begin (ctrl_new.mask_begin),
        .mask_end   (ctrl_new.mask_end),
        .mask       (mask)
    );

    // Merge under mask for inserts, plain AND for the others
    always_comb begin
        unique case (ctrl_new.op)
            rmw_pkg::RMW_OP_INSERT_IMM: result_nxt = insert_merge(rotated, target_r, mask);
            rmw_pkg::RMW_OP_INSERT_REG: result_nxt = insert_merge(rotated, target_r, mask);
            rmw_pkg::RMW_OP_AND_IMM:    result_nxt = rotated & mask;
            rmw_pkg::RMW_OP_AND_REG:    result_nxt = rotated & mask;
        endcase
    end

    // Field 0 value with summary overflow copied from the exception register
    assign cr0_nxt = cmp_zero(result_nxt, xer_r[rmw_pkg::XER_SO_BIT]);

    // ========================================================================
    // Registers
    // ========================================================================

    // Source operand, written by software only
    always_ff @(posedge CLK) begin
        if (RESET) begin
            source_r <= rmw_pkg::RST_WORD;
        end else if (wr_source) begin
            source_r <= PWDATA;
        end
    end

    // Count operand, written by software only
    always_ff @(posedge CLK) begin
        if (RESET) begin
            count_r <= rmw_pkg::RST_WORD;
        end else if (wr_count) begin
            count_r <= PWDATA;
        end
    end

    // Target: result of an operation, or a direct software write
    always_ff @(posedge CLK) begin
        if (RESET) begin
            target_r <= rmw_pkg::RST_WORD;
        end else if (exec) begin
            target_r <= result_nxt;
        end else if (wr_target) begin
            target_r <= PWDATA;
        end
    end

    // Last control word, kept for read back
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ctrl_r <= rmw_pkg::RST_CTRL;
        end else if (exec) begin
            ctrl_r <= ctrl_new;
        end
    end

    // Exception register: only software writes it, operations never do
    always_ff @(posedge CLK) begin
        if (RESET) begin
            xer_r <= rmw_pkg::RST_WORD;
        end else if (wr_xer) begin
            xer_r <= PWDATA;
        end
    end

    // Condition field 0 changes only for a recorded operation
    always_ff @(posedge CLK) begin
        if (RESET) begin
            cr0_r <= rmw_pkg::rmw_cr_t'(rmw_pkg::RST_CR0);
        end else if (exec && ctrl_new.record_flag) begin
            cr0_r <= cr0_nxt;
        end
    end

    // Count of executed operations, wraps silently
    always_ff @(posedge CLK) begin
        if (RESET) begin
            opcount_r <= rmw_pkg::RST_CNT;
        end else if (exec) begin
            opcount_r <= opcount_r + 1'b1;
        end
    end

    // ========================================================================
    // Read data, captured in the setup cycle
    // ========================================================================

    // Read multiplexer; unmapped offsets read as zero
    always_comb begin
        unique case (PADDR)
            rmw_pkg::OFS_SOURCE:  rd_mux = source_r;
            rmw_pkg::OFS_TARGET:  rd_mux = target_r;
            rmw_pkg::OFS_COUNT:   rd_mux = count_r;
            rmw_pkg::OFS_CONTROL: rd_mux = rmw_pkg::WORD_W'(ctrl_r);
            rmw_pkg::OFS_CR0:     rd_mux = rmw_pkg::WORD_W'(cr0_r);
            rmw_pkg::OFS_XER:     rd_mux = xer_r;
            rmw_pkg::OFS_OPCOUNT: rd_mux = rmw_pkg::WORD_W'(opcount_r);
            default:              rd_mux = rmw_pkg::RST_WORD;
        endcase
    end

    // Registers cannot change between setup and access except by this transfer,
    // so sampling in the setup cycle gives the value current at the access edge
    always_ff @(posedge CLK) begin
        if (RESET) begin
            prdata_r <= rmw_pkg::RST_WORD;
        end else if (setup_ph && !PWRITE) begin
            prdata_r <= rd_mux;
        end else if (access_done) begin
            prdata_r <= rmw_pkg::RST_WORD;
        end
    end

    // ========================================================================
    // Outputs, all straight from flip-flops
    // ========================================================================
    // Bus answer, result and condition field outputs
    assign PRDATA    = prdata_r;
    assign PREADY    = pready_r;
    assign PSLVERR   = pslverr_r;
    assign RESULT    = target_r;
    assign CR0_FLAGS = cr0_r;

endmodule

/* File: rmw_unit_sva.sv */
// Checker for the rotate-and-mask word unit, seeing only its top ports.
// Assumes the bind at the foot attaches it to the unit on one clock.
`timescale 1ns/1ps
module rmw_unit_sva (
    input wire logic                            CLK,       // Clock
    input wire logic                            RESET,     // Synchronous reset
    input wire logic                            PSEL,      // APB select
    input wire logic                            PENABLE,   // APB access phase
    input wire logic                            PWRITE,    // APB direction
    input wire logic [rmw_pkg::ADDR_W-1:0]      PADDR,     // APB address
    input wire logic [rmw_pkg::WORD_W-1:0]      PWDATA,    // APB write data
    input wire logic [rmw_pkg::WORD_W-1:0]      PRDATA,    // APB read data
    input wire logic                            PREADY,    // APB ready
    input wire logic                            PSLVERR,   // APB error
    input wire logic [rmw_pkg::WORD_W-1:0]      RESULT,    // Target value
    input wire logic [rmw_pkg::CR_W-1:0]        CR0_FLAGS  // Condition field 0
);
    // ====================
    // Sequences
    // ====================
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    sequence s_wr;
        PSEL && PENABLE && PREADY && PWRITE;
    endsequence
    sequence s_ctrl_wr;
        s_wr ##0 (PADDR == rmw_pkg::OFS_CONTROL);
    endsequence
    // ====================
    // Assertions
    // ====================
    chk_ready_one_cycle: assert property (PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");
    chk_setup_then_ready: assert property (PSEL && !PENABLE |-> !PREADY ##1 PREADY)
        else $error("ready not in the access cycle");
    chk_rdata_idle_zero: assert property (!PREADY |-> PRDATA == '0)
        else $error("read data outside access cycle");
    chk_err_with_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    chk_err_unmapped: assert property (PSEL && PENABLE && PREADY && PADDR > rmw_pkg::OFS_OPCOUNT
        |-> PSLVERR && PRDATA == '0) else $error("unmapped access not refused");
    chk_result_cause: assert property ($changed(RESULT) |->
        $past(PSEL) && $past(PENABLE) && $past(PWRITE) || $past(RESET))
        else $error("result changed without a write");
    chk_cr_hold_norec: assert property (s_ctrl_wr ##0 !PWDATA[15] |=> $stable(CR0_FLAGS))
        else $error("condition field changed without record");
    chk_cr_sign_rec: assert property (s_ctrl_wr ##0 PWDATA[15] |=>
        CR0_FLAGS[3:1] == {RESULT[31], !RESULT[31] && RESULT != '0, RESULT == '0})
        else $error("condition flags disagree with result");
    chk_cr_only_rec: assert property ($changed(CR0_FLAGS) |-> $past(RESET) ||
        $past(PSEL) && $past(PENABLE) && $past(PWRITE) &&
        $past(PADDR) == rmw_pkg::OFS_CONTROL && $past(PWDATA[15]))
        else $error("condition field changed");
endmodule

bind rmw_unit rmw_unit_sva rmw_unit_sva_inst (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .RESULT(RESULT), .CR0_FLAGS(CR0_FLAGS));

/* File: rmw_core_host.sv */
// Core-side partner: APB master issuing one register transfer at a time.
// Assumes the unit shares its clock and answers within a few cycles.
`timescale 1ns/1ps
module rmw_core_host (
    input  wire logic                           clk,     // Bus clock
    input  wire logic [rmw_pkg::WORD_W-1:0]     prdata,  // Read data
    input  wire logic                           pready,  // Transfer done
    input  wire logic                           pslverr, // Error answer
    output logic                                psel,    // Select
    output logic                                penable, // Access phase
    output logic                                pwrite,  // Direction
    output logic      [rmw_pkg::ADDR_W-1:0]     paddr,   // Byte address
    output logic      [rmw_pkg::WORD_W-1:0]     pwdata   // Write data
);
    // Idle bus at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
    end
    // Setup, access, bounded wait; released lines show inverted values
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output logic ok);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (!pready && n < 16);
        ok  = pready;
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule

/* File: testbench.sv */
// Self-checking bench: register accesses over APB run every operation.
// Assumes the unit answers each transfer and executes on CONTROL writes.
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, result;
    logic [3:0] cr_flags;
    logic [3:0] cr_exp = 4'h0;
    int err_count = 0;
    int num_checks = 0;
    int ops = 0;
    // ====================
    // Clock, design and partner
    // ====================
    always #12.5 clk = ~clk;
    rmw_unit rmw_unit_inst (.CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .RESULT(result), .CR0_FLAGS(cr_flags));
    rmw_core_host rmw_core_host_inst (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    // ====================
    // Checks and bus tasks
    // ====================
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        logic ok;
        rmw_core_host_inst.xfer(w, a, d, rd, err, ok);
        if (!ok) begin
            err_count++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        acc(1'b1, a, d, rd, err);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        acc(1'b0, a, 32'h0, rd, err);
        chk(name, rd, exp);
        chk("slave error", {31'h0, err}, 32'h0);
    endtask
    // ====================
    // Reference model
    // ====================
    function automatic logic [31:0] rotl(input logic [31:0] v, input int n);
        logic [63:0] t;
        t = {v, v} << n;
        return t[63:32];
    endfunction
    function automatic logic [31:0] ref_mask(input int mb, input int me);
        ref_mask = '0;
        for (int p = 0; p < 32; p++) begin
            if (mb < me + 1) ref_mask[31-p] = (p >= mb && p <= me);
            else if (mb == me + 1) ref_mask[31-p] = 1'b1;
            else ref_mask[31-p] = !(p >= me + 1 && p <= mb - 1);
        end
    endfunction
    // Loads operands, runs one operation, checks result, flags and exception word
    task automatic run_op(input logic [1:0] op, input logic rc, input logic [4:0] sh, input logic [4:0] mb,
                          input logic [4:0] me, input logic [31:0] src, input logic [31:0] tgt,
                          input logic [31:0] cnt, input logic [31:0] xer);
        logic [31:0] rot;
        logic [31:0] m;
        logic [31:0] res;
        rot = rotl(src, (op >= 2'h2) ? cnt[4:0] : sh);
        m = ref_mask(mb, me);
        res = (op == 2'h1 || op == 2'h2) ? (rot & m) : ((rot & m) | (tgt & ~m));
        if (rc) cr_exp = {res[31], !res[31] && res != 0, res == 0, xer[31]};
        wr(rmw_pkg::OFS_SOURCE, src);
        wr(rmw_pkg::OFS_TARGET, tgt);
        wr(rmw_pkg::OFS_COUNT, cnt);
        wr(rmw_pkg::OFS_XER, xer);
        wr(rmw_pkg::OFS_CONTROL, {14'h0, op, rc, sh, mb, me});
        ops++;
        rd_chk("target", rmw_pkg::OFS_TARGET, res);
        rd_chk("cr0", rmw_pkg::OFS_CR0, {28'h0, cr_exp});
        rd_chk("xer", rmw_pkg::OFS_XER, xer);
        rd_chk("control", rmw_pkg::OFS_CONTROL, {14'h0, op, rc, sh, mb, me});
        chk("result port", result, res);
        chk("cr0 port", {28'h0, cr_flags}, {28'h0, cr_exp});
    endtask
    // ====================
    // Main sequence
    // ====================
    initial begin
        logic [31:0] rd;
        logic err;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) rd_chk("reset value", 8'(i * 4), 32'h0);
        $display("test reset done");
        run_op(2'h0, 1'b0, 5'd2, 5'd0, 5'd29, 32'h90003000, 32'h00000003, 32'h0, 32'h0);
        run_op(2'h0, 1'b1, 5'd2, 5'd0, 5'd26, 32'h789A789B, 32'h30000003, 32'h0, 32'h0);
        run_op(2'h1, 1'b1, 5'd2, 5'd0, 5'd29, 32'hB0043000, 32'hFFFFFFFF, 32'h0, 32'h0);
        run_op(2'h2, 1'b0, 5'd0, 5'd0, 5'd29, 32'h90003000, 32'hFFFFFFFF, 32'hFFFFFFE2, 32'h0);
        run_op(2'h3, 1'b1, 5'd0, 5'd0, 5'd29, 32'hB0043000, 32'hFFFFFFFF, 32'h2, 32'h80000000);
        $display("test operations done");
        run_op(2'h1, 1'b1, 5'd0, 5'd5, 5'd4, 32'hA5A5F00F, 32'h0, 32'h0, 32'h0);
        run_op(2'h1, 1'b1, 5'd3, 5'd20, 5'd3, 32'h12345678, 32'h0, 32'h0, 32'h80000000);
        run_op(2'h1, 1'b1, 5'd0, 5'd31, 5'd0, 32'h7FFFFFFE, 32'h0, 32'h0, 32'h0);
        run_op(2'h3, 1'b0, 5'd0, 5'd31, 5'd31, 32'h1, 32'h0, 32'h1F, 32'h80000000);
        $display("test masks done");
        acc(1'b0, 8'h40, 32'h0, rd, err);
        chk("unmapped read data", rd, 32'h0);
        chk("unmapped read error", {31'h0, err}, 32'h1);
        acc(1'b1, 8'h40, 32'hFFFFFFFF, rd, err);
        chk("unmapped write error", {31'h0, err}, 32'h1);
        wr(rmw_pkg::OFS_CR0, 32'hF);
        rd_chk("cr0 read only", rmw_pkg::OFS_CR0, {28'h0, cr_exp});
        rd_chk("op count", rmw_pkg::OFS_OPCOUNT, 32'(ops));
        $display("test bus done");
        end_sim();
    end
endmodule
